// [arc_pkg.sv]
// Shared constants and types for the conversion result and computation register block
package arc_pkg;

    // Register byte addresses, one 32-bit aligned word per register
    localparam logic [7:0] ARC_CTRL_ADDR    = 8'h00;
    localparam logic [7:0] ARC_RES_HI_ADDR  = 8'h04;
    localparam logic [7:0] ARC_RES_LO_ADDR  = 8'h08;
    localparam logic [7:0] ARC_PREV_HI_ADDR = 8'h0c;
    localparam logic [7:0] ARC_PREV_LO_ADDR = 8'h10;
    localparam logic [7:0] ARC_ACC_HI_ADDR  = 8'h14;
    localparam logic [7:0] ARC_ACC_LO_ADDR  = 8'h18;
    localparam logic [7:0] ARC_STPT_HI_ADDR = 8'h1c;
    localparam logic [7:0] ARC_STPT_LO_ADDR = 8'h20;
    localparam logic [7:0] ARC_FLT_HI_ADDR  = 8'h24;
    localparam logic [7:0] ARC_FLT_LO_ADDR  = 8'h28;
    localparam logic [7:0] ARC_ERR_HI_ADDR  = 8'h2c;
    localparam logic [7:0] ARC_ERR_LO_ADDR  = 8'h30;
    localparam logic [7:0] ARC_LTH_HI_ADDR  = 8'h34;
    localparam logic [7:0] ARC_LTH_LO_ADDR  = 8'h38;
    localparam logic [7:0] ARC_UTH_HI_ADDR  = 8'h3c;
    localparam logic [7:0] ARC_UTH_LO_ADDR  = 8'h40;
    localparam logic [7:0] ARC_CNT_ADDR     = 8'h44;
    localparam logic [7:0] ARC_IST_ADDR     = 8'h48;
    localparam logic [7:0] ARC_ICLR_ADDR    = 8'h4c;
    localparam logic [7:0] ARC_IEN_ADDR     = 8'h50;
    localparam logic [7:0] ARC_THST_ADDR    = 8'h54;

    // Widths and reset values
    localparam int          ARC_RES_W     = 10;
    localparam int          ARC_CFG_W     = 14;
    localparam int          ARC_IRQ_W     = 2;
    localparam logic [7:0]  ARC_CNT_MAX   = 8'hff;
    localparam logic [15:0] ARC_WORD_RST  = 16'h0000;
    localparam logic [7:0]  ARC_BYTE_RST  = 8'h00;

    // Interrupt status bit positions
    localparam int ARC_IRQ_DONE = 0;
    localparam int ARC_IRQ_THR  = 1;

    typedef enum logic [2:0] {
        ARC_MODE_BASIC,
        ARC_MODE_ACCUMULATE,
        ARC_MODE_AVERAGE,
        ARC_MODE_BURST_AVERAGE,
        ARC_MODE_LOWPASS
    } arc_mode_e;

    // Control register layout, bit 13 down to bit 0
    typedef struct packed {
        logic [2:0] threshold_interrupt_mode;
        logic [2:0] error_calculation_mode;
        logic       result_format_select;
        logic       previous_source_select;
        logic [2:0] right_shift_select;
        logic [2:0] mode;
    } arc_cfg_s;

    // Sample handed over by the conversion core
    typedef struct packed {
        logic                 done;
        logic [ARC_RES_W-1:0] data;
    } arc_sample_s;

endpackage

// [arc_regs.sv]
// Conversion result, previous result, accumulator, filter and threshold registers on APB
//
// What this block does
// - In accumulate, average and burst-average modes the filter output is the accumulator shifted right by the shift field.
// - In low-pass mode the filter output takes the low-pass filter value instead of the shifted accumulator.
// - The filter output high byte holds the top bits including the sign of a signed 16-bit value.
// - Left justified, the high result byte holds result bits 9 to 2.
// - Left justified, the low result byte holds result bits 1 to 0 in bits 7 to 6, bits 5 to 0 read zero.
// - Right justified, the high result byte holds result bits 9 to 8 in bits 1 to 0, bits 7 to 2 read zero.
// - Right justified, the low result byte holds result bits 7 to 0.
// - With previous source select set, the filter output is copied into the previous pair at conversion start.
// - With previous source select clear, the conversion result is copied into the previous pair at conversion start.
// - A previous value taken from the result is justified like the result, following the format select.
// - A writable 16-bit two's complement accumulator is kept, the high byte carrying the sign.
// - A writable 16-bit setpoint serves as an operand of the error calculation in some calculation modes.
// - The error is compared with the lower and upper thresholds, flags are updated and an interrupt raised per mode.
// - The conversion counter counts each trigger and saturates at its maximum.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps

module arc_regs
    import arc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Conversion core
    input  wire logic        conv_start,
    input  wire arc_sample_s conv_sample,
    // Interrupt
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    arc_cfg_s             cfg;
    logic [ARC_RES_W-1:0] result;
    logic [15:0]          prev;
    logic signed [15:0]   acc;
    logic signed [15:0]   filt;
    logic signed [15:0]   stpt;
    logic signed [15:0]   err;
    logic signed [15:0]   lth;
    logic signed [15:0]   uth;
    logic [7:0]           cnt;
    logic [ARC_IRQ_W-1:0] ist;
    logic [ARC_IRQ_W-1:0] ien;
    logic                 below_lower;
    logic                 above_upper;
    logic                 ready_q;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    wire       access   = psel & penable;
    wire       wr_en    = access & ready_q & pwrite;
    wire       rd_load  = access & ~ready_q;
    wire [7:0] waddr    = paddr;
    wire       wr_ctrl  = wr_en & (waddr == ARC_CTRL_ADDR);
    wire       wr_res_h = wr_en & (waddr == ARC_RES_HI_ADDR);
    wire       wr_res_l = wr_en & (waddr == ARC_RES_LO_ADDR);
    wire       wr_acc_h = wr_en & (waddr == ARC_ACC_HI_ADDR);
    wire       wr_acc_l = wr_en & (waddr == ARC_ACC_LO_ADDR);
    wire       wr_stp_h = wr_en & (waddr == ARC_STPT_HI_ADDR);
    wire       wr_stp_l = wr_en & (waddr == ARC_STPT_LO_ADDR);
    wire       wr_lth_h = wr_en & (waddr == ARC_LTH_HI_ADDR);
    wire       wr_lth_l = wr_en & (waddr == ARC_LTH_LO_ADDR);
    wire       wr_uth_h = wr_en & (waddr == ARC_UTH_HI_ADDR);
    wire       wr_uth_l = wr_en & (waddr == ARC_UTH_LO_ADDR);
    wire       wr_cnt   = wr_en & (waddr == ARC_CNT_ADDR);
    wire       wr_iclr  = wr_en & (waddr == ARC_ICLR_ADDR);
    wire       wr_ien   = wr_en & (waddr == ARC_IEN_ADDR);
    wire [7:0] wbyte    = pwdata[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Result justification

    wire        fmt_right = cfg.result_format_select;
    // Reserved positions are filled with zeros so they read back as zero
    wire [15:0] res_fmt   = fmt_right ? {6'h00, result}
                                      : {result, 6'h00};

    // Software writes land in the bits that the current justification shows
    wire [ARC_RES_W-1:0] sw_result =
        wr_res_h ? (fmt_right ? {wbyte[1:0], result[7:0]} : {wbyte, result[1:0]}) :
        wr_res_l ? (fmt_right ? {result[9:8], wbyte}      : {result[9:2], wbyte[7:6]}) :
                   result;

    ////////////////////////////////////////////////////////////////////////////
    // Computation on a finished conversion

    wire                 done     = conv_sample.done;
    wire signed [15:0]   samp_ext = $signed({6'h00, conv_sample.data});
    wire arc_mode_e      mode     = arc_mode_e'(cfg.mode);
    wire [2:0]           shift    = cfg.right_shift_select;

    wire signed [15:0]   sw_acc   = wr_acc_h ? {wbyte, acc[7:0]} :
                                    wr_acc_l ? {acc[15:8], wbyte} : acc;
    wire                 acc_mode = (mode == ARC_MODE_ACCUMULATE) |
                                    (mode == ARC_MODE_AVERAGE) |
                                    (mode == ARC_MODE_BURST_AVERAGE) |
                                    (mode == ARC_MODE_LOWPASS);
    // Accumulator wraps in two's complement; software must rescale long runs
    wire signed [15:0]   hw_acc   = 16'(acc + samp_ext);
    wire signed [15:0]   next_acc = (done & acc_mode) ? hw_acc : sw_acc;

    // First-order low-pass: filter moves toward the sample by 1/2^shift of the gap
    wire signed [16:0]   lpf_gap  = 17'(samp_ext) - 17'(filt);
    wire signed [16:0]   lpf_step = lpf_gap >>> shift;
    wire signed [15:0]   lpf_out  = 16'(filt + lpf_step[15:0]);
    // Arithmetic shift keeps the sign in the upper byte
    wire signed [15:0]   acc_shr  = next_acc >>> shift;
    wire signed [15:0]   next_filt = (mode == ARC_MODE_LOWPASS) ? lpf_out
                                                                : acc_shr;

    // Error operand selection
    wire signed [15:0]   prev_s   = prev;
    logic signed [15:0]  next_err;
    always_comb begin
        unique case (cfg.error_calculation_mode)
            3'h0:    next_err = 16'(samp_ext - prev_s);
            3'h1:    next_err = 16'(samp_ext - stpt);
            3'h2:    next_err = 16'(next_filt - stpt);
            3'h3:    next_err = 16'(next_filt - prev_s);
            default: next_err = 16'(stpt - next_filt);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Threshold comparison

    wire next_below = next_err < lth;
    wire next_above = next_err > uth;
    logic thr_hit;
    always_comb begin
        unique case (cfg.threshold_interrupt_mode)
            3'h0:    thr_hit = 1'b0;
            3'h1:    thr_hit = next_below;
            3'h2:    thr_hit = ~next_below;
            3'h3:    thr_hit = ~next_below & ~next_above;
            3'h4:    thr_hit = next_below | next_above;
            3'h5:    thr_hit = ~next_above;
            3'h6:    thr_hit = next_above;
            default: thr_hit = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Previous result and counter

    // Source is sampled before the result changes, so a start and a finish
    // in the same cycle still capture the old sample
    wire [15:0] prev_src  = cfg.previous_source_select ? filt
                                                       : res_fmt;
    wire [15:0] next_prev = conv_start ? prev_src : prev;
    wire [7:0]  cnt_inc   = (cnt == ARC_CNT_MAX) ? cnt : 8'(cnt + 8'h01);
    wire [7:0]  next_cnt  = conv_start ? cnt_inc : (wr_cnt ? wbyte : cnt);

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status

    wire [ARC_IRQ_W-1:0] ist_set  = {done & thr_hit, done};
    wire [ARC_IRQ_W-1:0] ist_clr  = wr_iclr ? pwdata[ARC_IRQ_W-1:0] : '0;
    // Hardware set wins over a clear landing in the same cycle
    wire [ARC_IRQ_W-1:0] next_ist = (ist & ~ist_clr) | ist_set;
    wire [ARC_IRQ_W-1:0] next_ien = wr_ien ? pwdata[ARC_IRQ_W-1:0] : ien;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux

    logic [31:0] rd_mux;
    logic        rd_err;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        unique case (paddr)
            ARC_CTRL_ADDR:    rd_mux = {18'h00000, cfg};
            ARC_RES_HI_ADDR:  rd_mux = {24'h000000, res_fmt[15:8]};
            ARC_RES_LO_ADDR:  rd_mux = {24'h000000, res_fmt[7:0]};
            ARC_PREV_HI_ADDR: rd_mux = {24'h000000, prev[15:8]};
            ARC_PREV_LO_ADDR: rd_mux = {24'h000000, prev[7:0]};
            ARC_ACC_HI_ADDR:  rd_mux = {24'h000000, acc[15:8]};
            ARC_ACC_LO_ADDR:  rd_mux = {24'h000000, acc[7:0]};
            ARC_STPT_HI_ADDR: rd_mux = {24'h000000, stpt[15:8]};
            ARC_STPT_LO_ADDR: rd_mux = {24'h000000, stpt[7:0]};
            ARC_FLT_HI_ADDR:  rd_mux = {24'h000000, filt[15:8]};
            ARC_FLT_LO_ADDR:  rd_mux = {24'h000000, filt[7:0]};
            ARC_ERR_HI_ADDR:  rd_mux = {24'h000000, err[15:8]};
            ARC_ERR_LO_ADDR:  rd_mux = {24'h000000, err[7:0]};
            ARC_LTH_HI_ADDR:  rd_mux = {24'h000000, lth[15:8]};
            ARC_LTH_LO_ADDR:  rd_mux = {24'h000000, lth[7:0]};
            ARC_UTH_HI_ADDR:  rd_mux = {24'h000000, uth[15:8]};
            ARC_UTH_LO_ADDR:  rd_mux = {24'h000000, uth[7:0]};
            ARC_CNT_ADDR:     rd_mux = {24'h000000, cnt};
            ARC_IST_ADDR:     rd_mux = {30'h00000000, ist};
            ARC_ICLR_ADDR:    rd_mux = 32'h0000_0000;
            ARC_IEN_ADDR:     rd_mux = {30'h00000000, ien};
            ARC_THST_ADDR:    rd_mux = {30'h00000000, above_upper, below_lower};
            default:          rd_err = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer: one wait state, data and error registered

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            ready_q <= rd_load;
            prdata  <= rd_load ? (pwrite ? 32'h0000_0000 : rd_mux) : prdata;
            pslverr <= rd_load & rd_err;
        end
    end

    assign pready = ready_q;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and software-owned operands

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg  <= arc_cfg_s'(14'h0000);
            stpt <= ARC_WORD_RST;
            lth  <= ARC_WORD_RST;
            uth  <= ARC_WORD_RST;
            ien  <= '0;
        end else begin
            if (wr_ctrl) begin
                cfg <= arc_cfg_s'(pwdata[ARC_CFG_W-1:0]);
            end
            stpt <= wr_stp_h ? {wbyte, stpt[7:0]} : wr_stp_l ? {stpt[15:8], wbyte} : stpt;
            lth  <= wr_lth_h ? {wbyte, lth[7:0]}  : wr_lth_l ? {lth[15:8], wbyte}  : lth;
            uth  <= wr_uth_h ? {wbyte, uth[7:0]}  : wr_uth_l ? {uth[15:8], wbyte}  : uth;
            ien  <= next_ien;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion datapath; a finishing conversion wins over result writes and, outside basic mode, accumulator writes

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result      <= '0;
            prev        <= ARC_WORD_RST;
            acc         <= ARC_WORD_RST;
            filt        <= ARC_WORD_RST;
            err         <= ARC_WORD_RST;
            cnt         <= ARC_BYTE_RST;
            below_lower <= 1'b0;
            above_upper <= 1'b0;
        end else begin
            result <= done ? conv_sample.data : sw_result;
            prev   <= next_prev;
            acc    <= next_acc;
            cnt    <= next_cnt;
            if (done) begin
                filt        <= next_filt;
                err         <= next_err;
                below_lower <= next_below;
                above_upper <= next_above;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and output

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist <= '0;
            irq <= 1'b0;
        end else begin
            ist <= next_ist;
            irq <= |(next_ist & next_ien);
        end
    end

endmodule // arc_regs

// [arc_regs_asserts.sv]
// Checker of bus timing, result layout and interrupt causes
`timescale 1ns/1ps
module arc_regs_asserts
    import arc_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Core and interrupt
    input wire logic        conv_start,
    input wire arc_sample_s conv_sample,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic fmt;
    wire  rd_end = pready && !pwrite;
    wire  wr_end = pready && pwrite;
    // Shadow of the format bit, so reserved bits can be judged per layout
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) fmt <= 1'b0;
        else if (wr_end && paddr == ARC_CTRL_ADDR) fmt <= pwdata[7];
    ////////////////////////////////
    a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("no answer");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_ready_cause: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("ready without access");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_err_unmap: assert property (pready && paddr > ARC_THST_ADDR |-> pslverr)
        else $error("unmapped accepted");
    a_hi_right: assert property (rd_end && fmt && paddr == ARC_RES_HI_ADDR |->
        prdata[7:2] == 6'h00) else $error("right high reserved bits");
    a_lo_left: assert property (rd_end && !fmt && paddr == ARC_RES_LO_ADDR |->
        prdata[5:0] == 6'h00) else $error("left low reserved bits");
    a_irq_rise: assert property ($rose(irq) |-> $past(conv_sample.done) ||
        $past(conv_sample.done, 2) || $past(wr_end) || $past(wr_end, 2)) else $error("irq rise");
    a_irq_fall: assert property ($fell(irq) |-> $past(wr_end) || $past(wr_end, 2))
        else $error("irq fall");
    c_err: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
    c_both: cover property (conv_start && conv_sample.done);
endmodule // arc_regs_asserts

bind arc_regs arc_regs_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .conv_start, .conv_sample, .irq);

// [arc_core_model.sv]
// Behavioural conversion core that issues triggers and samples
`timescale 1ns/1ps
module arc_core_model
    import arc_pkg::*;
(
    // Clock
    input  wire logic   pclk,
    // Core outputs
    output logic        conv_start,
    output arc_sample_s conv_sample
);
    initial begin
        conv_start  = 1'b0;
        conv_sample = '{done: 1'b0, data: 10'h2aa};
    end
    // Gap 0 makes start and done coincide; data is inverted after done so stale values show
    task automatic convert(input logic [9:0] d, input int gap);
        @(posedge pclk);
        conv_start <= 1'b1;
        repeat (gap) @(posedge pclk) conv_start <= 1'b0;
        conv_sample <= '{done: 1'b1, data: d};
        @(posedge pclk);
        conv_start <= 1'b0;
        conv_sample <= '{done: 1'b0, data: ~d};
    endtask
endmodule // arc_core_model

// [arc_regs_test.sv]
// Self-checking testbench of the result and computation registers
`timescale 1ns/1ps
module arc_regs_test;
    import arc_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, irq, conv_start;
    arc_sample_s conv_sample;
    logic [33:0] q[$], e;
    int          n_fail = 0, checks = 0;
    logic [9:0]  d, d2;
    logic [15:0] acc, flt, fp, stp;
    logic [2:0]  s;
    logic        b, u;
    logic [7:0]  hv;

    always #4 pclk = ~pclk;
    arc_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .conv_start, .conv_sample, .irq);
    arc_core_model i_core (.pclk, .conv_start, .conv_sample);
    ////////////////////////////////
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Expectation is queued before the request; the monitor pops it when ready shows
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                       input logic [32:0] x);
        q.push_back({w, x});
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until the edge at which ready is seen high; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, v, 33'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] x);
        apb(1'b0, a, 32'h0, {17'h0, x});
    endtask
    task automatic irq_is(input logic v);
        repeat (2) @(negedge pclk);
        chk({32'h0, irq}, {32'h0, v});
    endtask
    function automatic logic [15:0] res_hi(input logic f, input logic [9:0] x);
        return f ? {14'h0, x[9:8]} : {8'h0, x[9:2]};
    endfunction
    function automatic logic [15:0] res_lo(input logic f, input logic [9:0] x);
        return f ? {8'h0, x[7:0]} : {8'h0, x[1:0], 6'h0};
    endfunction
    ////////////////////////////////
    always @(negedge pclk)
        if (pready === 1'b1) begin
            e = q.pop_front();
            if (e[33]) chk({32'h0, pslverr}, {32'h0, e[32]});
            else chk({pslverr, prdata}, e[32:0]);
        end
    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        end_sim();
    end
    initial begin
        void'($urandom(21));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(ARC_CTRL_ADDR, 16'h0);
        apb(1'b0, 8'h58, 32'h0, 33'h100000000);
        apb(1'b1, 8'h58, 32'hff, 33'h100000000);
        wr(ARC_FLT_LO_ADDR, 32'h5a);
        rd(ARC_FLT_LO_ADDR, 16'h0);
        $display("test reset and decode done");
        for (int f = 0; f < 2; f++) begin
            wr(ARC_CTRL_ADDR, {24'h0, f[0], 7'h0});
            d = 10'($urandom);
            i_core.convert(d, 1);
            rd(ARC_RES_HI_ADDR, res_hi(f[0], d));
            rd(ARC_RES_LO_ADDR, res_lo(f[0], d));
            d2 = 10'($urandom);
            i_core.convert(d2, 3 * f);
            rd(ARC_PREV_HI_ADDR, res_hi(f[0], d));
            rd(ARC_PREV_LO_ADDR, res_lo(f[0], d));
        end
        $display("test format and previous done");
        for (int m = 1; m < 4; m++) begin
            s = 3'($urandom);
            wr(ARC_CTRL_ADDR, {25'h0, 1'b1, s, m[2:0]});
            wr(ARC_ACC_HI_ADDR, 32'hff);
            wr(ARC_ACC_LO_ADDR, 32'h00);
            d = 10'($urandom);
            d2 = 10'($urandom);
            i_core.convert(d, 1);
            i_core.convert(d2, 2);
            acc = 16'hff00 + d;
            fp = $signed(acc) >>> s;
            acc = acc + d2;
            flt = $signed(acc) >>> s;
            rd(ARC_ACC_HI_ADDR, {8'h0, acc[15:8]});
            rd(ARC_ACC_LO_ADDR, {8'h0, acc[7:0]});
            rd(ARC_FLT_HI_ADDR, {8'h0, flt[15:8]});
            rd(ARC_FLT_LO_ADDR, {8'h0, flt[7:0]});
            rd(ARC_PREV_HI_ADDR, {8'h0, fp[15:8]});
            rd(ARC_PREV_LO_ADDR, {8'h0, fp[7:0]});
        end
        $display("test accumulate modes done");
        wr(ARC_CTRL_ADDR, {26'h0, s, 3'h4});
        d = 10'($urandom);
        i_core.convert(d, 1);
        acc = {6'h0, d} - flt;
        acc = $signed(acc) >>> s;
        flt = flt + acc;
        rd(ARC_FLT_HI_ADDR, {8'h0, flt[15:8]});
        rd(ARC_FLT_LO_ADDR, {8'h0, flt[7:0]});
        $display("test low-pass done");
        stp = {6'h1, 10'($urandom)};
        wr(ARC_STPT_HI_ADDR, {24'h0, stp[15:8]});
        wr(ARC_STPT_LO_ADDR, {24'h0, stp[7:0]});
        wr(ARC_IEN_ADDR, 32'h2);
        wr(ARC_CTRL_ADDR, 32'h0900);
        d = 10'($urandom);
        i_core.convert(d, 1);
        acc = {6'h0, d} - stp;
        rd(ARC_ERR_HI_ADDR, {8'h0, acc[15:8]});
        rd(ARC_ERR_LO_ADDR, {8'h0, acc[7:0]});
        rd(ARC_THST_ADDR, 16'h1);
        rd(ARC_IST_ADDR, 16'h3);
        irq_is(1'b1);
        wr(ARC_IEN_ADDR, 32'h0);
        irq_is(1'b0);
        wr(ARC_IEN_ADDR, 32'h3);
        irq_is(1'b1);
        wr(ARC_ICLR_ADDR, 32'h3);
        irq_is(1'b0);
        rd(ARC_IST_ADDR, 16'h0);
        $display("test threshold and interrupt done");
        wr(ARC_CNT_ADDR, 32'hfe);
        i_core.convert(d, 0);
        i_core.convert(d, 1);
        rd(ARC_CNT_ADDR, 16'hff);
        $display("test counter done");
        // Basic mode, shift 0: filter equals the written accumulator; every calc and irq mode
        wr(ARC_ACC_HI_ADDR, 32'h01);
        wr(ARC_ACC_LO_ADDR, 32'h80);
        wr(ARC_LTH_HI_ADDR, 32'hfc);
        wr(ARC_UTH_HI_ADDR, 32'hff);
        for (int t = 0; t < 8; t++) begin
            wr(ARC_ICLR_ADDR, 32'h3);
            wr(ARC_CTRL_ADDR, {18'h0, t[2:0], t[2:0], 8'h0});
            fp = {d, 6'h0};
            d = 10'($urandom);
            i_core.convert(d, 1);
            case (t)
                0:       acc = {6'h0, d} - fp;
                1:       acc = {6'h0, d} - stp;
                2:       acc = 16'h0180 - stp;
                3:       acc = 16'h0180 - fp;
                default: acc = stp - 16'h0180;
            endcase
            b = $signed(acc) < $signed(16'hfc00);
            u = $signed(acc) > $signed(16'hff00);
            hv = {1'b1, u, ~u, b | u, ~b & ~u, ~b, b, 1'b0};
            rd(ARC_ERR_HI_ADDR, {8'h0, acc[15:8]});
            rd(ARC_ERR_LO_ADDR, {8'h0, acc[7:0]});
            rd(ARC_THST_ADDR, {14'h0, u, b});
            rd(ARC_IST_ADDR, {14'h0, hv[t], 1'b1});
        end
        $display("test error and threshold modes done");
        end_sim();
    end
endmodule // arc_regs_test
